//--- hdl/sysctl_map.vh
// Bit map, reset value and timing counts of the system control register
`ifndef SYSCTL_MAP_VH
`define SYSCTL_MAP_VH
`define SCR_RESET       16'h0000
`define B_RX_EN         6
`define B_RX_FORCE      7
`define B_NXM_CLR       8
`define B_MAINT         9
`define B_NXM           10
`define B_INIT          11
`define B_STO_EN        12
`define B_TX_EN         13
`define B_OVF           14
`define B_TX_DONE       15
`define CLK_NS          100
`define NXM_TIMEOUT_NS  20000
`define NXM_TIMEOUT_CYC (`NXM_TIMEOUT_NS / `CLK_NS)
`define CLR_PULSE_NS    40
`define CLR_PULSE_CYC   ((`CLR_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- hdl/system_control_irq_register.v
// System control register with receive and transmit interrupt requests
`timescale 1ns/1ps
`include "sysctl_map.vh"
module system_control_irq_register (
  input  wire        clk,
  input  wire        srst,
  input  wire        low_byte_write_strobe,
  input  wire        high_byte_write_strobe,
  input  wire [15:0] write_data,
  input  wire        storage_overflow,
  input  wire        byte_count_overflow,
  input  wire        dma_read_transaction,
  input  wire        slave_acknowledge,
  input  wire [5:0]  silo_fill_level,
  input  wire [5:0]  silo_alarm_level,
  input  wire        silo_char_at_output,
  input  wire        next_received_char_read,
  output reg  [15:0] system_control_reg,
  output reg  [3:0]  line_select,
  output reg  [1:0]  address_extension,
  output reg         internal_init,
  output reg         maint_mode,
  output reg         silo_data_ready,
  output reg         rx_irq_request,
  output reg         tx_irq_request,
  output reg         tx_finished_pulse,
  output reg         nxm_clear_pulse,
  output reg         bus_timeout_flag,
  output reg         dma_abandon
);

  // Counts arrive as 32-bit integers; cut them to the counter widths
  localparam [31:0] TIMEOUT_FULL = `NXM_TIMEOUT_CYC;
  localparam [7:0]  TIMEOUT_CYC  = TIMEOUT_FULL[7:0];
  localparam [31:0] CLR_FULL     = `CLR_PULSE_CYC;
  localparam [1:0]  CLR_CYC      = CLR_FULL[1:0];

  reg  [15:0] scr_nxt;
  reg         ready_nxt;
  reg         timeout_nxt;
  reg         cond_prev_r;
  reg  [2:0]  ack_sync_r;
  reg  [7:0]  wait_cnt_r;
  reg         ack_flt_r;
  reg  [15:0] sw_nxt;
  reg  [1:0]  clr_cnt_r;
  reg  [1:0]  clr_cnt_nxt;
  wire        ack_seen;
  wire        ready_cond;
  wire        timeout_hit;
  wire        maint;
  wire        force_we;
  wire        direct_we;
  wire        rx_nxt;
  wire        tx_nxt;

  assign maint       = system_control_reg[`B_MAINT];
  assign ack_seen    = ack_flt_r;
  assign force_we    = low_byte_write_strobe & maint;
  assign direct_we   = high_byte_write_strobe & maint;
  assign ready_cond  = (silo_fill_level > silo_alarm_level) &
                       silo_char_at_output;
  assign timeout_hit = dma_read_transaction & ~ack_seen &
                       (wait_cnt_r == TIMEOUT_CYC - 8'h01);

  // Acknowledge comes from the asynchronous bus
  always @(posedge clk) begin
    if (srst) begin
      ack_sync_r <= 3'h0;
    end else begin
      ack_sync_r <= {ack_sync_r[1:0], slave_acknowledge};
    end
  end

  // A change counts only once the second and third stages agree
  always @(posedge clk) begin
    if (srst) begin
      ack_flt_r <= 1'b0;
    end else if (ack_sync_r[1] == ack_sync_r[2]) begin
      ack_flt_r <= ack_sync_r[2];
    end
  end

  // Wait counter for our own DMA read; abandoned at 20 us
  always @(posedge clk) begin
    if (srst) begin
      wait_cnt_r <= 8'h00;
    end else if (!dma_read_transaction || ack_seen || timeout_hit) begin
      wait_cnt_r <= 8'h00;
    end else begin
      wait_cnt_r <= wait_cnt_r + 8'h01;
    end
  end

  // Tells the bus master to drop the read it is waiting on
  always @(posedge clk) begin
    if (srst) begin
      dma_abandon <= 1'b0;
    end else begin
      dma_abandon <= timeout_hit;
    end
  end

  // Software writes; bits 7, 10 and 14 take a write only in maintenance
  always @* begin
    sw_nxt = system_control_reg;
    if (low_byte_write_strobe) begin
      sw_nxt[3:0]      = write_data[3:0];
      sw_nxt[5:4]      = write_data[5:4];
      sw_nxt[`B_RX_EN] = write_data[`B_RX_EN];
    end
    if (force_we) begin
      sw_nxt[`B_RX_FORCE] = write_data[`B_RX_FORCE];
    end
    if (high_byte_write_strobe) begin
      sw_nxt[`B_NXM_CLR] = write_data[`B_NXM_CLR];
      sw_nxt[`B_MAINT]   = write_data[`B_MAINT];
      sw_nxt[`B_INIT]    = write_data[`B_INIT];
      sw_nxt[`B_STO_EN]  = write_data[`B_STO_EN];
      sw_nxt[`B_TX_EN]   = write_data[`B_TX_EN];
      sw_nxt[`B_TX_DONE] = write_data[`B_TX_DONE];
    end
    if (direct_we) begin
      sw_nxt[`B_NXM] = write_data[`B_NXM];
      sw_nxt[`B_OVF] = write_data[`B_OVF];
    end
  end

  // Hardware side after software, so an event beats a same-cycle clear
  always @* begin
    scr_nxt = sw_nxt;
    // Pulse length comes from the clear counter below
    if (nxm_clear_pulse) begin
      scr_nxt[`B_NXM]     = 1'b0;
      scr_nxt[`B_NXM_CLR] = 1'b0;
    end
    if (storage_overflow) begin
      scr_nxt[`B_OVF] = 1'b1;
    end
    if (byte_count_overflow) begin
      scr_nxt[`B_TX_DONE] = 1'b1;
    end
    if (timeout_hit) begin
      scr_nxt[`B_NXM] = 1'b1;
    end
  end

  always @* begin
    ready_nxt = silo_data_ready;
    if (next_received_char_read) begin
      ready_nxt = 1'b0;
    end
    // Edge of the condition, so a read is not undone by a stale level
    if (ready_cond && !cond_prev_r) begin
      ready_nxt = 1'b1;
    end
  end

  // Timeout flag follows bit 10 except maintenance writes: set by the timeout, dropped by the pulse
  always @* begin
    timeout_nxt = bus_timeout_flag;
    if (nxm_clear_pulse) begin
      timeout_nxt = 1'b0;
    end
    if (timeout_hit) begin
      timeout_nxt = 1'b1;
    end
  end

  // Forced bit 7 keeps the request high, so data ready adds no edge
  assign rx_nxt = (scr_nxt[`B_RX_EN] &
                   (scr_nxt[`B_RX_FORCE] | ready_nxt)) |
                  (scr_nxt[`B_STO_EN] & scr_nxt[`B_OVF]);
  assign tx_nxt = scr_nxt[`B_TX_EN] &
                  (scr_nxt[`B_TX_DONE] | scr_nxt[`B_NXM]);

  // 40 ns rounds up to one 100 ns clock; a written bit 8 starts it when idle
  always @* begin
    clr_cnt_nxt = clr_cnt_r;
    if (clr_cnt_r != 2'h0) begin
      clr_cnt_nxt = clr_cnt_r - 2'h1;
    end else if (scr_nxt[`B_NXM_CLR]) begin
      clr_cnt_nxt = CLR_CYC;
    end
  end

  // Counter of clock periods left in the clear pulse
  always @(posedge clk) begin
    if (srst) begin
      clr_cnt_r <= 2'h0;
    end else begin
      clr_cnt_r <= clr_cnt_nxt;
    end
  end

  // Register contents as software reads them
  always @(posedge clk) begin
    if (srst) begin
      system_control_reg <= `SCR_RESET;
    end else begin
      system_control_reg <= scr_nxt;
    end
  end

  // Line select for parameter writes and address memory
  always @(posedge clk) begin
    if (srst) begin
      line_select <= 4'h0;
    end else begin
      line_select <= scr_nxt[3:0];
    end
  end

  // Top two bits of the DMA read address
  always @(posedge clk) begin
    if (srst) begin
      address_extension <= 2'h0;
    end else begin
      address_extension <= scr_nxt[5:4];
    end
  end

  // A level; the address logic turns it into the initialize
  always @(posedge clk) begin
    if (srst) begin
      internal_init <= 1'b0;
    end else begin
      internal_init <= scr_nxt[`B_INIT];
    end
  end

  // Maintenance mode, for the loopback path outside this block
  always @(posedge clk) begin
    if (srst) begin
      maint_mode <= 1'b0;
    end else begin
      maint_mode <= scr_nxt[`B_MAINT];
    end
  end

  // Data ready stays up until the next received character is read
  always @(posedge clk) begin
    if (srst) begin
      silo_data_ready <= 1'b0;
    end else begin
      silo_data_ready <= ready_nxt;
    end
  end

  // Last value of the silo condition, for the edge detector
  always @(posedge clk) begin
    if (srst) begin
      cond_prev_r <= 1'b0;
    end else begin
      cond_prev_r <= ready_cond;
    end
  end

  // Timeout flag is shared with the bus master
  always @(posedge clk) begin
    if (srst) begin
      bus_timeout_flag <= 1'b0;
    end else begin
      bus_timeout_flag <= timeout_nxt;
    end
  end

  // One clock after the byte counter wraps, with bit 15
  always @(posedge clk) begin
    if (srst) begin
      tx_finished_pulse <= 1'b0;
    end else begin
      tx_finished_pulse <= byte_count_overflow;
    end
  end

  // Pulse lasts while the counter runs; it also drops bit 8 itself
  always @(posedge clk) begin
    if (srst) begin
      nxm_clear_pulse <= 1'b0;
    end else begin
      nxm_clear_pulse <= (clr_cnt_nxt != 2'h0);
    end
  end

  // Levels, held until flag or enable clears
  always @(posedge clk) begin
    if (srst) begin
      rx_irq_request <= 1'b0;
    end else begin
      rx_irq_request <= rx_nxt;
    end
  end

  // Both transmit causes are gated by bit 13
  always @(posedge clk) begin
    if (srst) begin
      tx_irq_request <= 1'b0;
    end else begin
      tx_irq_request <= tx_nxt;
    end
  end

endmodule

//--- sim/mem_slave.sv
// Memory slave model that answers device-mastered reads
`timescale 1ns/1ps
module mem_slave (
  input  wire      clk,
  input  wire      dma_read_transaction,
  input  wire      nxm_addr,
  output reg       slave_acknowledge = 1'b0
);
  reg [1:0] dly_r = 2'b00;
  always @(posedge clk) begin
    dly_r <= dma_read_transaction ? {dly_r[0], 1'b1} : 2'b00;
    // A nonexistent address never answers
    slave_acknowledge <= dly_r[1] & ~nxm_addr;
  end
endmodule

//--- sim/sysctl_chk_assertions.sv
// Checker of the system control register and its requests
`timescale 1ns/1ps
module sysctl_chk (
  input wire        clk,
  input wire        srst,
  input wire        low_byte_write_strobe,
  input wire        high_byte_write_strobe,
  input wire [15:0] write_data,
  input wire        storage_overflow,
  input wire        byte_count_overflow,
  input wire [15:0] system_control_reg,
  input wire [3:0]  line_select,
  input wire        silo_data_ready,
  input wire        rx_irq_request,
  input wire        tx_irq_request,
  input wire        tx_finished_pulse,
  input wire        nxm_clear_pulse,
  input wire        bus_timeout_flag,
  input wire        dma_abandon
);
  wire [15:0] r = system_control_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_clr;
    nxm_clear_pulse ##1 !r[10] && !r[8] && !bus_timeout_flag;
  endsequence
  property p_rx;
    rx_irq_request == (r[6] && (r[7] || silo_data_ready) || r[12] && r[14]);
  endproperty
  property p_tx; tx_irq_request == (r[13] && (r[15] || r[10])); endproperty
  property p_ls; line_select == r[3:0]; endproperty
  property p_lo;
    low_byte_write_strobe |=> r[6:0] == $past(write_data[6:0]);
  endproperty
  property p_hold;
    !r[9] && !storage_overflow |=>
      r[7] == $past(r[7]) && r[14] == $past(r[14]);
  endproperty
  property p_ovf; storage_overflow |=> r[14]; endproperty
  property p_fin; byte_count_overflow |=> tx_finished_pulse && r[15]; endproperty
  property p_clr;
    high_byte_write_strobe && write_data[8] && !r[9] |=> s_clr;
  endproperty
  property p_to; dma_abandon |-> ##[0:1] r[10] && bus_timeout_flag; endproperty
  a_rx: assert property (p_rx) else $error("rx wrong");
  a_tx: assert property (p_tx) else $error("tx wrong");
  a_ls: assert property (p_ls) else $error("line select wrong");
  a_lo: assert property (p_lo) else $error("low byte wrong");
  a_hold: assert property (p_hold) else $error("bit held wrong");
  a_ovf: assert property (p_ovf) else $error("overflow not set");
  a_fin: assert property (p_fin) else $error("finish wrong");
  a_clr: assert property (p_clr) else $error("clear wrong");
  a_to: assert property (p_to) else $error("timeout flag wrong");
endmodule

//--- sim/system_control_irq_register_tb.sv
// Self-checking bench of the system control register
`timescale 1ns/1ps
module system_control_irq_register_tb;
  reg clk = 0, srst = 1, lo = 0, hi = 0, sov = 0, bco = 0, dma = 0;
  reg chr = 0, rd = 0, nxm = 0;
  reg [15:0] wd = 0;
  reg [5:0] fill = 0;
  wire [15:0] r;
  wire rxq, txq, tfp, ab, ack;
  wire [3:0] ls;
  wire [1:0] ext;
  wire ini, mm, sdr, clp, bto;
  integer n_fail = 0, n_checks = 0, cyc = 0, k;
  always #50 clk = ~clk;
  mem_slave slv (.clk(clk), .dma_read_transaction(dma), .nxm_addr(nxm),
    .slave_acknowledge(ack));
  system_control_irq_register DUT (.clk(clk), .srst(srst),
    .low_byte_write_strobe(lo), .high_byte_write_strobe(hi),
    .write_data(wd), .storage_overflow(sov), .byte_count_overflow(bco),
    .dma_read_transaction(dma), .slave_acknowledge(ack),
    .silo_fill_level(fill), .silo_alarm_level(6'h02),
    .silo_char_at_output(chr), .next_received_char_read(rd),
    .system_control_reg(r), .line_select(ls), .address_extension(ext),
    .internal_init(ini), .maint_mode(mm), .silo_data_ready(sdr),
    .rx_irq_request(rxq), .tx_irq_request(txq), .tx_finished_pulse(tfp),
    .nxm_clear_pulse(clp), .bus_timeout_flag(bto), .dma_abandon(ab));
  task close_out;
    begin
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input l, input h, input [15:0] d);
    begin
      @(negedge clk) {lo, hi, wd} = {l, h, d};
      @(negedge clk) {lo, hi} = 2'b00;
    end
  endtask
  task t_rx;
    begin
      wr(1, 0, 16'h0075);
      chk("lowbyte", 16'h0075, r);
      chk("lsel", 5, ls);
      chk("aext", 3, ext);
      {fill, chr} = {6'h03, 1'b1};
      repeat (3) @(negedge clk);
      chk("rxq", 1, rxq);
      chk("ready", 1, sdr);
      @(negedge clk) {rd, fill} = {1'b1, 6'h00};
      @(negedge clk) rd = 0;
      @(negedge clk) chk("rxq", 0, rxq);
      chk("ready", 0, sdr);
    end
  endtask
  task t_maint;
    begin
      wr(1, 0, 16'h00c0);
      chk("b7", 0, r[7]);
      wr(0, 1, 16'h0200);
      chk("maint", 1, mm);
      wr(1, 0, 16'h00c0);
      chk("rxq", 1, rxq);
      wr(0, 1, 16'h2600);
      chk("txq", 1, txq);
      wr(0, 1, 16'h2400);
      wr(0, 1, 16'h2000);
      chk("b10", 1, r[10]);
      wr(0, 1, 16'h2100);
      chk("clrpls", 1, clp);
      @(negedge clk) chk("b10", 0, r[10]);
      chk("txq", 0, txq);
    end
  endtask
  task t_ev;
    begin
      wr(0, 1, 16'h3800);
      chk("init", 1, ini);
      @(negedge clk) bco = 1;
      @(negedge clk) bco = 0;
      chk("tfp", 1, tfp);
      chk("txq", 1, txq);
      @(negedge clk) sov = 1;
      @(negedge clk) sov = 0;
      chk("ovf", 1, r[14]);
      chk("rxq", 1, rxq);
      wr(0, 1, 16'h8000);
      chk("txq", 0, txq);
      chk("init", 0, ini);
    end
  endtask
  task t_dma;
    begin
      {nxm, dma, k} = {2'b11, 32'd0};
      while (ab !== 1'b1 && k < 300) @(negedge clk) k = k + 1;
      @(negedge clk) dma = 0;
      chk("b10", 1, r[10]);
      chk("tmo", 1, bto);
      chk("wait", 1, k >= 195 && k <= 205);
      wr(0, 1, 16'h0100);
      @(negedge clk) {nxm, dma} = 2'b01;
      repeat (250) @(negedge clk);
      dma = 0;
      chk("b10", 0, r[10]);
      chk("tmo", 0, bto);
    end
  endtask
  initial begin
    repeat (2) @(negedge clk);
    srst = 0;
    t_rx;
    t_maint;
    t_ev;
    t_dma;
    close_out;
  end
endmodule
bind system_control_irq_register sysctl_chk u_chk (.*);
